// [core/umd_text_display.v]
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "umd_consts.vh"

// Summary of operation
// - text comes from 32 words at offsets 9 to 40 above the word base.
// - the buffer maps to 4 lines of 16 cells, low byte left, high right.
// - codes 20H-7DH, A1H-DFH and double-byte Japanese codes are shown.
// - a double-byte code split over a line end shows as two spaces.
// - the command bit on replaces the main screen, only from that screen.
// - the command bit off cancels the message and returns to main.
// - the status bit is high while the message screen is shown.
// - an OK press on the message screen switches to the menu.
// - button states appear as bits 0 to 3 of the system bit word.

module umd_text_display #(
	parameter REFRESH_CYC = `UMD_REFRESH_US * `UMD_CLK_MHZ
) (
	// clock and reset
	input  wire        clock,
	input  wire        rst,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	// front panel buttons (pins)
	input  wire [3:0]  btn_pin,
	// host word area read port
	output reg         mem_rd,
	output reg  [15:0] mem_addr,
	input  wire [15:0] mem_rdata,
	// character cell writes
	output reg         cell_we,
	output reg  [1:0]  cell_line,
	output reg  [3:0]  cell_col,
	output reg  [7:0]  cell_code,
	// current screen
	output reg  [1:0]  screen
);

	// ------------------------------------------------------------
	// local state
	// ------------------------------------------------------------
	localparam PH_IDLE   = 2'd0;
	localparam PH_FETCH  = 2'd1;
	localparam PH_RENDER = 2'd2;
	localparam PH_WAIT   = 2'd3;

	reg  [15:0] text_q [0:`UMD_TEXT_WORDS-1];
	reg  [15:0] wbase_q;
	reg         cmd_q;
	reg  [3:0]  btn_s1_q;
	reg  [3:0]  btn_q;
	reg         ok_prev_q;
	reg  [1:0]  ph_q;
	reg  [5:0]  idx_q;
	reg         cap_q;
	reg  [4:0]  cap_idx_q;
	reg  [4:0]  rd_idx_q;
	reg         trail_q;
	reg         wrap_q;
	reg  [31:0] wait_q;
	reg  [1:0]  screen_d;

	wire [15:0] cur_word;
	wire [7:0]  cur_byte;
	wire        is_single;
	wire        is_lead;
	wire        ok_press;
	wire        stat_bit;

	// ------------------------------------------------------------
	// button synchroniser
	// ------------------------------------------------------------
	// pins are asynchronous: two flops before any logic looks at them
	always @(posedge clock) begin
		if (rst) begin
			btn_s1_q  <= 4'h0;
			btn_q     <= 4'h0;
			ok_prev_q <= 1'b0;
		end else begin
			btn_s1_q  <= btn_pin;
			btn_q     <= btn_s1_q;
			ok_prev_q <= btn_q[`UMD_BIT_OK];
		end
	end

	assign ok_press = btn_q[`UMD_BIT_OK] & ~ok_prev_q;
	assign stat_bit = (screen == `UMD_SCR_MSG);

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	// system bit word and word base; unmapped words read zero
	always @(posedge clock) begin
		if (rst) begin
			cmd_q     <= 1'b0;
			wbase_q   <= `UMD_WBASE_RST;
			reg_rdata <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == `UMD_REG_BITS)
				cmd_q <= reg_wdata[`UMD_BIT_CMD];
			if (reg_wr && reg_addr == `UMD_REG_WBASE)
				wbase_q <= reg_wdata;
			if (reg_rd) begin
				case (reg_addr)
				`UMD_REG_BITS: begin
					reg_rdata <= {9'h000, stat_bit, 1'b0, cmd_q,
					              btn_q};
				end
				`UMD_REG_WBASE: begin
					reg_rdata <= wbase_q;
				end
				default: begin
					reg_rdata <= 16'h0000;
				end
				endcase
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	// ------------------------------------------------------------
	// screen selection
	// ------------------------------------------------------------
	// the command is level sensitive, so a command left on while in the
	// menu does not pull the message back until it is cleared, ESC returns to main and it is set again
	always @* begin
		screen_d = screen;
		case (screen)
		`UMD_SCR_MAIN: begin
			if (cmd_q)
				screen_d = `UMD_SCR_MSG;
		end
		`UMD_SCR_MSG: begin
			if (!cmd_q)
				screen_d = `UMD_SCR_MAIN;
			else if (ok_press)
				screen_d = `UMD_SCR_MENU;
		end
		`UMD_SCR_MENU: begin
			if (btn_q[`UMD_BIT_ESC] && !cmd_q)
				screen_d = `UMD_SCR_MAIN;
		end
		default: begin
			screen_d = `UMD_SCR_MAIN;
		end
		endcase
	end

	always @(posedge clock) begin
		if (rst)
			screen <= `UMD_SCR_MAIN;
		else
			screen <= screen_d;
	end

	// ------------------------------------------------------------
	// cell renderer
	// ------------------------------------------------------------
	assign cur_word = text_q[idx_q[5:1]];
	assign cur_byte = idx_q[0] ? cur_word[15:8] : cur_word[7:0];

	umd_code_class u_class (
		.code      (cur_byte),
		.is_single (is_single),
		.is_lead   (is_lead)
	);

	// fetch, render, then wait; the cycle repeats while the message is up
	always @(posedge clock) begin
		if (rst) begin
			ph_q      <= PH_IDLE;
			idx_q     <= 6'd0;
			cap_q     <= 1'b0;
			cap_idx_q <= 5'd0;
			rd_idx_q  <= 5'd0;
			trail_q   <= 1'b0;
			wrap_q    <= 1'b0;
			wait_q    <= 32'd0;
			mem_rd    <= 1'b0;
			mem_addr  <= 16'h0000;
			cell_we   <= 1'b0;
			cell_line <= 2'd0;
			cell_col  <= 4'd0;
			cell_code <= 8'h00;
		end else begin
			mem_rd  <= 1'b0;
			cell_we <= 1'b0;
			cap_q   <= mem_rd;
			// index of the word whose read is on the port now; idx_q has
			// already moved one word further
			cap_idx_q <= rd_idx_q;
			// read data stands one cycle after the strobe
			if (cap_q)
				text_q[cap_idx_q] <= mem_rdata;
			if (screen != `UMD_SCR_MSG) begin
				ph_q <= PH_IDLE;
			end else begin
				case (ph_q)
				PH_IDLE: begin
					ph_q  <= PH_FETCH;
					idx_q <= 6'd0;
				end
				PH_FETCH: begin
					mem_rd   <= 1'b1;
					rd_idx_q <= idx_q[4:0];
					mem_addr <= wbase_q + `UMD_TEXT_FIRST
					            + {11'h000, idx_q[4:0]};
					if (idx_q[4:0] == 5'd31) begin
						ph_q  <= PH_RENDER;
						idx_q <= 6'd0;
					end else begin
						idx_q <= idx_q + 6'd1;
					end
					trail_q <= 1'b0;
					wrap_q  <= 1'b0;
				end
				PH_RENDER: begin
					// first two render cycles wait for the last word to land
					if (!cap_q) begin
						cell_we   <= 1'b1;
						cell_line <= idx_q[5:4];
						cell_col  <= idx_q[3:0];
						if (wrap_q) begin
							cell_code <= `UMD_SPACE;
							wrap_q    <= 1'b0;
						end else if (trail_q) begin
							cell_code <= cur_byte;
							trail_q   <= 1'b0;
						end else if (is_lead &&
						             idx_q[3:0] == 4'hF) begin
							cell_code <= `UMD_SPACE;
							wrap_q    <= 1'b1;
						end else if (is_lead) begin
							cell_code <= cur_byte;
							trail_q   <= 1'b1;
						end else if (is_single) begin
							cell_code <= cur_byte;
						end else begin
							cell_code <= `UMD_SPACE;
						end
						if (idx_q == 6'd63) begin
							ph_q   <= PH_WAIT;
							wait_q <= 32'd0;
						end else begin
							idx_q <= idx_q + 6'd1;
						end
					end
				end
				PH_WAIT: begin
					// host edits show up without cycling the command
					if (wait_q >= REFRESH_CYC - 1) begin
						ph_q  <= PH_FETCH;
						idx_q <= 6'd0;
					end else begin
						wait_q <= wait_q + 32'd1;
					end
				end
				default: begin
					ph_q <= PH_IDLE;
				end
				endcase
			end
		end
	end

endmodule // umd_text_display

// [core/umd_consts.vh]
`ifndef UMD_CONSTS_VH
`define UMD_CONSTS_VH

// ------------------------------------------------------------
// register port map (word addresses)
// ------------------------------------------------------------
`define UMD_REG_BITS       4'h0
`define UMD_REG_WBASE      4'h1
`define UMD_WBASE_RST      16'h0000

// ------------------------------------------------------------
// system bit positions
// ------------------------------------------------------------
`define UMD_BIT_OK         0
`define UMD_BIT_ESC        1
`define UMD_BIT_MINUS      2
`define UMD_BIT_PLUS       3
`define UMD_BIT_CMD        4
`define UMD_BIT_STAT       6

// ------------------------------------------------------------
// text buffer layout
// ------------------------------------------------------------
`define UMD_TEXT_FIRST     16'h0009
`define UMD_TEXT_LAST      16'h0028
`define UMD_TEXT_WORDS     32
`define UMD_LINE_CELLS     16

// ------------------------------------------------------------
// character codes
// ------------------------------------------------------------
`define UMD_SB_LO1         8'h20
`define UMD_SB_HI1         8'h7D
`define UMD_SB_LO2         8'hA1
`define UMD_SB_HI2         8'hDF
`define UMD_DB_LO1         8'h81
`define UMD_DB_HI1         8'h9F
`define UMD_DB_LO2         8'hE0
`define UMD_DB_HI2         8'hEF
`define UMD_SPACE          8'h20

// ------------------------------------------------------------
// screens
// ------------------------------------------------------------
`define UMD_SCR_MAIN       2'h0
`define UMD_SCR_MSG        2'h1
`define UMD_SCR_MENU       2'h2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define UMD_CLK_MHZ        40
`define UMD_REFRESH_US     10000

`endif

// [core/umd_code_class.v]
`timescale 1ns/1ps
`include "umd_consts.vh"

module umd_code_class (
	// byte under test
	input  wire [7:0] code,
	// classification
	output wire       is_single,
	output wire       is_lead
);

	// printable single-byte ranges
	assign is_single = ((code >= `UMD_SB_LO1) && (code <= `UMD_SB_HI1)) ||
	                   ((code >= `UMD_SB_LO2) && (code <= `UMD_SB_HI2));

	// first byte of a double-byte kanji or kana code
	assign is_lead = ((code >= `UMD_DB_LO1) && (code <= `UMD_DB_HI1)) ||
	                 ((code >= `UMD_DB_LO2) && (code <= `UMD_DB_HI2));

endmodule // umd_code_class

// [dv/umd_host_mem.sv]
`timescale 1ns/1ps
// host word area seen by the display's read port
module umd_host_mem (
	// clock
	input  wire         clock,
	// read port
	input  wire         mem_rd,
	input  wire  [15:0] mem_addr,
	output logic [15:0] mem_rdata
);
	logic [15:0] mem [0:255];
	// word stands one cycle after the read; otherwise it inverts every
	// cycle, so a sample one cycle late finds the inverse of the word
	always @(posedge clock)
		if (mem_rd) mem_rdata <= mem[mem_addr[7:0]];
		else mem_rdata <= ~mem_rdata;
endmodule // umd_host_mem

// [dv/umd_text_display_properties.sv]
`timescale 1ns/1ps
module umd_text_display_properties (
	// clock and reset
	input wire        clock,
	input wire        rst,
	// register port and buttons
	input wire [3:0]  reg_addr,
	input wire [15:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [15:0] reg_rdata,
	input wire [3:0]  btn_pin,
	// host reads, cells, screen
	input wire        mem_rd,
	input wire [15:0] mem_addr,
	input wire        cell_we,
	input wire [1:0]  cell_line,
	input wire [3:0]  cell_col,
	input wire [1:0]  screen
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic [15:0] base_q;
	wire         cmd_wr = reg_wr && reg_addr == 4'h0;
	// shadow of the word base, so fetch addresses can be judged
	always @(posedge clock)
		if (rst) base_q <= 16'h0000;
		else if (reg_wr && reg_addr == 4'h1) base_q <= reg_wdata;
	stat_read_a: assert property (reg_rd && reg_addr == 4'h0 |=>
		reg_rdata[6] == ($past(screen) == 2'h1)) else $error("status bit");
	fetch_step_a: assert property (mem_rd && $past(mem_rd) |->
		mem_addr == $past(mem_addr) + 16'h0001) else $error("fetch order");
	fetch_range_a: assert property (mem_rd |->
		mem_addr - base_q >= 16'h0009 && mem_addr - base_q <= 16'h0028)
		else $error("fetch address");
	cmd_show_a: assert property (cmd_wr && reg_wdata[4] &&
		screen == 2'h0 |-> ##2 screen == 2'h1) else $error("no show");
	cmd_cancel_a: assert property (cmd_wr && !reg_wdata[4] &&
		screen == 2'h1 |-> ##2 screen == 2'h0) else $error("no cancel");
	menu_hold_a: assert property (cmd_wr && reg_wdata[4] &&
		screen == 2'h2 |=> (screen != 2'h1)[*3]) else $error("shown in menu");
	ok_menu_a: assert property (screen == 2'h1 && $rose(btn_pin[0])
		|-> ##[1:6] screen == 2'h2) else $error("no menu");
	cell_order_a: assert property (cell_we && $past(cell_we) |->
		{cell_line, cell_col} == $past({cell_line, cell_col}) + 6'h01)
		else $error("cell order");
endmodule // umd_text_display_properties

bind umd_text_display umd_text_display_properties chk_u (.clock(clock),
	.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .btn_pin(btn_pin),
	.mem_rd(mem_rd), .mem_addr(mem_addr), .cell_we(cell_we),
	.cell_line(cell_line), .cell_col(cell_col), .screen(screen));

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic        clock, rst, reg_wr, reg_rd, mem_rd, cell_we;
	logic [3:0]  reg_addr, btn_pin, cell_col;
	logic [15:0] reg_wdata, reg_rdata, mem_addr, mem_rdata;
	logic [1:0]  cell_line, screen;
	logic [7:0]  cell_code;
	logic [7:0]  cells [0:63];
	int          n_mismatch, check_count;
	int          n_cells = 0;
	// rows: high byte is the cell, low byte the code it must show
	localparam logic [15:0] rows [0:19] = '{16'h0041, 16'h0142, 16'h027D,
		16'h0320, 16'h0420, 16'h05A1, 16'h06DF, 16'h07E0, 16'h0840, 16'h0941,
		16'h0AEF, 16'h0B80, 16'h0C20, 16'h0D21, 16'h0E43, 16'h0F20, 16'h1020,
		16'h1144, 16'h3E30, 16'h3F20};
	localparam logic [15:0] txt [0:8] = '{16'h4241, 16'h7E7D, 16'hA11F,
		16'hE0DF, 16'h4140, 16'h80EF, 16'h2180, 16'h8143, 16'h4440};
	// short refresh keeps the periodic re-read inside the run
	umd_text_display #(.REFRESH_CYC(200)) dut_u (.clock(clock), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .btn_pin(btn_pin),
		.mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.cell_we(cell_we), .cell_line(cell_line), .cell_col(cell_col),
		.cell_code(cell_code), .screen(screen));
	umd_host_mem host_u (.clock(clock), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata));
	// 25 ns clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// capture every cell the display writes
	always @(posedge clock) if (cell_we) begin
		cells[{cell_line, cell_col}] <= cell_code;
		n_cells <= n_cells + 1;
	end
	task automatic chk(input string nm, input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk("reg read", e, reg_rdata);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// counts from a snapshot, so the capture process stays the only writer
	task automatic wait_cells();
		int start;
		start = n_cells;
		for (int i = 0; i < 1000 && n_cells - start < 64; i++)
			@(posedge clock);
		#1 chk("cell count", 16'h0040, 16'(n_cells - start));
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata, btn_pin} = '0;
		{n_mismatch, check_count} = '0;
		for (int i = 0; i < 256; i++) host_u.mem[i] = 16'h2020;
		foreach (txt[i]) host_u.mem[8'h49 + i] = txt[i];
		host_u.mem[8'h68] = 16'h9F30;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		wr(4'h1, 16'h0040);
		rd(4'h1, 16'h0040);
		wr(4'h9, 16'hFFFF);
		rd(4'h9, 16'h0000);
		@(posedge clock) btn_pin <= 4'hE;
		wt(4);
		rd(4'h0, 16'h000E);
		@(posedge clock) btn_pin <= 4'h0;
		wr(4'h0, 16'h0010);
		wait_cells();
		foreach (rows[r]) chk("cell", rows[r] & 16'h00FF, {8'h00,
			cells[rows[r][13:8]]});
		rd(4'h0, 16'h0050);
		host_u.mem[8'h49] = 16'h5A59;
		wait_cells();
		chk("refresh", 16'h0059, {8'h00, cells[0]});
		@(posedge clock) btn_pin <= 4'h1;
		wt(6);
		chk("screen", 16'h0002, {14'h0, screen});
		rd(4'h0, 16'h0011);
		@(posedge clock) btn_pin <= 4'h0;
		wr(4'h0, 16'h0010);
		wt(3);
		chk("screen", 16'h0002, {14'h0, screen});
		wr(4'h0, 16'h0000);
		@(posedge clock) btn_pin <= 4'h2;
		wt(6);
		chk("screen", 16'h0000, {14'h0, screen});
		@(posedge clock) btn_pin <= 4'h0;
		wr(4'h0, 16'h0010);
		wt(2);
		chk("screen", 16'h0001, {14'h0, screen});
		wr(4'h0, 16'h0000);
		wt(2);
		chk("screen", 16'h0000, {14'h0, screen});
		wr(4'h0, 16'h0010);
		wt(4);
		@(posedge clock) rst <= 1'b1;
		wt(2);
		chk("screen", 16'h0000, {14'h0, screen});
		chk("fetch", 16'h0000, {15'h0, mem_rd});
		@(posedge clock) rst <= 1'b0;
		rd(4'h1, 16'h0000);
		rd(4'h0, 16'h0000);
		print_verdict();
	end
endmodule // testbench
